// *** design/pdc_div.sv ***
// integer counter divider driven by input enable pulses
`timescale 1ns/1ps
module pdc_div
  import pdc_pkg::*;
#(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         clr,
  input  wire logic [W-1:0] ratio,
  input  wire logic         in_en,
  output logic              out_en
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic [W-1:0] ratio;
    logic         out;
  } pdc_div_st_t;

  pdc_div_st_t s_ff;
  pdc_div_st_t nxt_s;

  // ==========================================================
  // count down; ratio latched while held clear
  always_comb begin
    nxt_s     = s_ff;
    nxt_s.out = 1'b0;
    if (clr) begin
      nxt_s.cnt   = ratio;
      nxt_s.ratio = ratio;
    end else if (in_en) begin
      if (s_ff.cnt == '0) begin
        nxt_s.out = 1'b1;  // ratio zero passes every pulse
        nxt_s.cnt = s_ff.ratio;
      end else begin
        nxt_s.cnt = s_ff.cnt - 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign out_en = s_ff.out;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_div_bypass: assert property (
    !clr && in_en && s_ff.ratio == '0 |=> out_en)
    else $error("ratio one divider dropped a pulse");

endmodule : pdc_div

// *** design/pdc_pfd.sv ***
// phase frequency detector giving pump up and pump down levels
`timescale 1ns/1ps
module pdc_pfd
  import pdc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic clr,
  input  wire logic ref_en,
  input  wire logic fb_en,
  output logic      up,
  output logic      dn
);

  typedef struct packed {
    logic up;
    logic dn;
  } pdc_pfd_st_t;

  pdc_pfd_st_t s_ff;
  pdc_pfd_st_t nxt_s;

  // ==========================================================
  // edge sets its pump; both set means both cleared
  always_comb begin
    nxt_s = s_ff;
    if (ref_en) nxt_s.up = 1'b1;
    if (fb_en) nxt_s.dn = 1'b1;
    if (nxt_s.up && nxt_s.dn) nxt_s = '0;
    if (clr) nxt_s = '0;
  end

  // state register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign up = s_ff.up;
  assign dn = s_ff.dn;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_pfd_pump_up: assert property (
    !clr && ref_en && !fb_en && !dn |=> up && !dn)
    else $error("reference edge did not pump up");

endmodule : pdc_pfd

// *** design/pdc_top.sv ***
// pll divider chain, reference mux and reset/calibration sequencer
// How it works
// - normal operation only while both active-low pins are high
// - either pin low forces and holds reset
// - leaving pin reset reloads defaults, then calibrates
// - soft bit written one then zero resets, keeping register contents
// - soft-started calibration uses bank settings at that write
// - calibration starts only with supply good and timer expired
// - all clock outputs held in reset during calibration
// - reference pre-divider, 4-bit, ratio 1 to 16, before mux
// - input divider, 14-bit, ratio 1 to 16384, after mux
// - feedback 8-bit stage cascaded into 10-bit stage
// - prescaler a feeds outputs 0,1,4,5 and feedback; b feeds 2,3,6,7
// - detector compares reference and feedback, drives pump up/down
// - upper cmos outputs drive one or two in-phase signals, slew select
// - wait 64k detector reference cycles first
// - then wait 64k feedback cycles
// - calibration lasts exactly 128k detector reference cycles
// - outputs enabled right when calibration completes
`timescale 1ns/1ps
`include "pdc_consts.svh"
module pdc_top
  import pdc_pkg::*;
#(
  parameter int REF_WAIT    = `PDC_REF_WAIT,
  parameter int FB_WAIT     = `PDC_FB_WAIT,
  parameter int CAL_LEN     = `PDC_CAL_LEN,
  parameter int ACT_TIMEOUT = `PDC_ACT_TIMEOUT,
  parameter int PS_W        = 3
) (
  input  wire logic        MCLK,
  input  wire logic        RST_B,
  input  wire logic        POWER_DOWN_PIN_N,
  input  wire logic        HARD_RESET_PIN_N,
  input  wire logic        SUPPLY_OK,
  input  wire logic        PRI_REF,
  input  wire logic        SEC_REF,
  input  wire logic        VCO_CLK,
  input  wire logic [3:0]  ADDR,
  input  wire logic [15:0] WR_DATA,
  input  wire logic        WR_EN,
  input  wire logic        RD_EN,
  output logic      [15:0] RD_DATA,
  output logic      [7:0]  Y,
  output logic      [3:0]  Y_ALT,
  output logic      [3:0]  SLEW_FAST,
  output logic             OUT_EN,
  output logic             CAL_ACTIVE,
  output logic             PUMP_UP,
  output logic             PUMP_DN
);

  typedef struct packed {
    pdc_state_t     st;
    logic [16:0]    cnt;
    logic [2:0]     ctrl;
    logic [3:0]     rdiv;
    logic [13:0]    mdiv;
    logic [7:0]     n1div;
    logic [9:0]     n2div;
    logic [PS_W-1:0] psa;
    logic [PS_W-1:0] psb;
    logic [7:0]     outcfg;
    logic [3:0]     act_rdiv;
    logic [13:0]    act_mdiv;
    logic [7:0]     act_n1;
    logic [9:0]     act_n2;
    logic [PS_W-1:0] act_psa;
    logic [PS_W-1:0] act_psb;
    logic           pri_q;
    logic           sec_q;
    logic           vco_q;
    logic [15:0]    idle;
    logic           sel_sec;
    logic [7:0]     y;
    logic [3:0]     y_alt;
    logic           out_en;
    logic           cal;
    logic [15:0]    rd;
  } pdc_top_st_t;

  pdc_top_st_t s_ff;
  pdc_top_st_t nxt_s;

  logic pins_ok;
  logic soft_go;
  logic div_clr;
  logic pri_rise;
  logic sec_rise;
  logic vco_rise;
  logic ref_en;
  logic r_out;
  logic m_out;
  logic n1_out;
  logic n2_out;
  logic psa_out;
  logic psb_out;

  // ==========================================================
  // level qualifiers and edge enables
  assign pins_ok  = POWER_DOWN_PIN_N & HARD_RESET_PIN_N;
  assign soft_go  = WR_EN && ADDR == `PDC_A_CTRL && !WR_DATA[`PDC_B_SOFT]
                    && s_ff.ctrl[`PDC_B_SOFT];
  assign div_clr  = s_ff.st == PDC_ST_RESET;
  assign pri_rise = PRI_REF & ~s_ff.pri_q;
  assign sec_rise = SEC_REF & ~s_ff.sec_q;
  assign vco_rise = VCO_CLK & ~s_ff.vco_q;
  assign ref_en   = s_ff.sel_sec ? sec_rise : r_out;

  // ==========================================================
  // divider chain
  pdc_div #(.W(4)) u_rdiv (
    .clk(MCLK), .rst_b(RST_B), .clr(div_clr), .ratio(s_ff.act_rdiv),
    .in_en(pri_rise), .out_en(r_out));
  pdc_div #(.W(14)) u_mdiv (
    .clk(MCLK), .rst_b(RST_B), .clr(div_clr), .ratio(s_ff.act_mdiv),
    .in_en(ref_en), .out_en(m_out));
  pdc_div #(.W(PS_W)) u_psa (
    .clk(MCLK), .rst_b(RST_B), .clr(div_clr), .ratio(s_ff.act_psa),
    .in_en(vco_rise), .out_en(psa_out));
  pdc_div #(.W(PS_W)) u_psb (
    .clk(MCLK), .rst_b(RST_B), .clr(div_clr), .ratio(s_ff.act_psb),
    .in_en(vco_rise), .out_en(psb_out));
  pdc_div #(.W(8)) u_n1 (
    .clk(MCLK), .rst_b(RST_B), .clr(div_clr), .ratio(s_ff.act_n1),
    .in_en(psa_out), .out_en(n1_out));
  pdc_div #(.W(10)) u_n2 (
    .clk(MCLK), .rst_b(RST_B), .clr(div_clr), .ratio(s_ff.act_n2),
    .in_en(n1_out), .out_en(n2_out));

  // detector on reference and feedback
  pdc_pfd u_pfd (
    .clk(MCLK), .rst_b(RST_B), .clr(div_clr), .ref_en(m_out),
    .fb_en(n2_out), .up(PUMP_UP), .dn(PUMP_DN));

  // ==========================================================
  // next state: register bank, mux, sequencer, outputs
  always_comb begin
    nxt_s       = s_ff;
    nxt_s.rd    = '0;
    nxt_s.pri_q = PRI_REF;
    nxt_s.sec_q = SEC_REF;
    nxt_s.vco_q = VCO_CLK;
    // read port, data the cycle after the strobe
    if (RD_EN) begin
      unique case (ADDR)
        `PDC_A_CTRL:   nxt_s.rd = 16'(s_ff.ctrl);
        `PDC_A_RDIV:   nxt_s.rd = 16'(s_ff.rdiv);
        `PDC_A_MDIV:   nxt_s.rd = 16'(s_ff.mdiv);
        `PDC_A_N1DIV:  nxt_s.rd = 16'(s_ff.n1div);
        `PDC_A_N2DIV:  nxt_s.rd = 16'(s_ff.n2div);
        `PDC_A_PSA:    nxt_s.rd = 16'(s_ff.psa);
        `PDC_A_PSB:    nxt_s.rd = 16'(s_ff.psb);
        `PDC_A_OUTCFG: nxt_s.rd = 16'(s_ff.outcfg);
        `PDC_A_STATUS: begin
          nxt_s.rd[`PDC_B_ST +: 3]   = 3'(s_ff.st);
          nxt_s.rd[`PDC_B_SUPPLY]    = SUPPLY_OK;
          nxt_s.rd[`PDC_B_SECSEL]    = s_ff.sel_sec;
          nxt_s.rd[`PDC_B_OUTEN]     = s_ff.out_en;
          nxt_s.rd[`PDC_B_PRIIDLE]   = s_ff.idle >= 16'(ACT_TIMEOUT);
        end
        default:       nxt_s.rd = '0;
      endcase
    end
    // write port
    if (WR_EN) begin
      unique case (ADDR)
        `PDC_A_CTRL:   nxt_s.ctrl   = WR_DATA[2:0];
        `PDC_A_RDIV:   nxt_s.rdiv   = WR_DATA[3:0];
        `PDC_A_MDIV:   nxt_s.mdiv   = WR_DATA[13:0];
        `PDC_A_N1DIV:  nxt_s.n1div  = WR_DATA[7:0];
        `PDC_A_N2DIV:  nxt_s.n2div  = WR_DATA[9:0];
        `PDC_A_PSA:    nxt_s.psa    = WR_DATA[PS_W-1:0];
        `PDC_A_PSB:    nxt_s.psb    = WR_DATA[PS_W-1:0];
        `PDC_A_OUTCFG: nxt_s.outcfg = WR_DATA[7:0];
        default:       ;
      endcase
    end
    // primary activity watch for auto selection
    if (r_out) nxt_s.idle = '0;
    else if (s_ff.idle < 16'(ACT_TIMEOUT)) nxt_s.idle = s_ff.idle + 1'b1;
    if (s_ff.ctrl[`PDC_B_AUTO]) nxt_s.sel_sec = s_ff.idle >= 16'(ACT_TIMEOUT);
    else nxt_s.sel_sec = s_ff.ctrl[`PDC_B_SEL];
    // startup sequencer
    unique case (s_ff.st)
      PDC_ST_RESET: begin
        nxt_s.st  = PDC_ST_REFWAIT;
        nxt_s.cnt = '0;
      end
      PDC_ST_REFWAIT: if (m_out) begin
        if (s_ff.cnt == 17'(REF_WAIT - 1)) begin
          if (SUPPLY_OK) begin
            nxt_s.st  = PDC_ST_FBWAIT;
            nxt_s.cnt = '0;
          end
        end else begin
          nxt_s.cnt = s_ff.cnt + 1'b1;
        end
      end
      PDC_ST_FBWAIT: if (n2_out) begin
        if (s_ff.cnt == 17'(FB_WAIT - 1)) begin
          nxt_s.st  = PDC_ST_CAL;
          nxt_s.cnt = '0;
        end else begin
          nxt_s.cnt = s_ff.cnt + 1'b1;
        end
      end
      PDC_ST_CAL: if (m_out) begin
        if (s_ff.cnt == 17'(CAL_LEN - 1)) begin
          nxt_s.st     = PDC_ST_RUN;
          nxt_s.out_en = 1'b1;
        end else begin
          nxt_s.cnt = s_ff.cnt + 1'b1;
        end
      end
      PDC_ST_RUN: ;
    endcase
    // soft sequence: reset with the bank as it stands
    if (soft_go) begin
      nxt_s.st       = PDC_ST_RESET;
      nxt_s.out_en   = 1'b0;
      nxt_s.act_rdiv = s_ff.rdiv;
      nxt_s.act_mdiv = s_ff.mdiv;
      nxt_s.act_n1   = s_ff.n1div;
      nxt_s.act_n2   = s_ff.n2div;
      nxt_s.act_psa  = s_ff.psa;
      nxt_s.act_psb  = s_ff.psb;
    end
    // pin reset: hold and reload defaults
    if (!pins_ok) begin
      nxt_s.st       = PDC_ST_RESET;
      nxt_s.out_en   = 1'b0;
      nxt_s.ctrl     = `PDC_D_CTRL;
      nxt_s.rdiv     = `PDC_D_RDIV;
      nxt_s.mdiv     = `PDC_D_MDIV;
      nxt_s.n1div    = `PDC_D_N1DIV;
      nxt_s.n2div    = `PDC_D_N2DIV;
      nxt_s.psa      = PS_W'(`PDC_D_PSA);
      nxt_s.psb      = PS_W'(`PDC_D_PSB);
      nxt_s.outcfg   = `PDC_D_OUTCFG;
      nxt_s.act_rdiv = `PDC_D_RDIV;
      nxt_s.act_mdiv = `PDC_D_MDIV;
      nxt_s.act_n1   = `PDC_D_N1DIV;
      nxt_s.act_n2   = `PDC_D_N2DIV;
      nxt_s.act_psa  = PS_W'(`PDC_D_PSA);
      nxt_s.act_psb  = PS_W'(`PDC_D_PSB);
    end
    // output stages toggle on their prescaler, dark unless enabled
    if (!nxt_s.out_en) begin
      nxt_s.y = '0;
    end else begin
      if (psa_out) nxt_s.y = s_ff.y ^ 8'h33;  // outputs 0,1,4,5
      if (psb_out) nxt_s.y = nxt_s.y ^ 8'hCC;  // outputs 2,3,6,7
    end
    nxt_s.y_alt = nxt_s.y[7:4] & nxt_s.outcfg[`PDC_B_DUAL +: 4];
    nxt_s.cal   = nxt_s.st == PDC_ST_CAL;  // calibration flag kept as a flop
  end

  // state register, power-on values equal pin-reset values
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      s_ff          <= '0;
      s_ff.st       <= PDC_ST_RESET;
      s_ff.ctrl     <= `PDC_D_CTRL;
      s_ff.psa      <= PS_W'(`PDC_D_PSA);
      s_ff.psb      <= PS_W'(`PDC_D_PSB);
      s_ff.act_psa  <= PS_W'(`PDC_D_PSA);
      s_ff.act_psb  <= PS_W'(`PDC_D_PSB);
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ==========================================================
  // outputs straight from state
  assign RD_DATA    = s_ff.rd;
  assign Y          = s_ff.y;
  assign Y_ALT      = s_ff.y_alt;
  assign SLEW_FAST  = s_ff.outcfg[`PDC_B_SLEW +: 4];
  assign OUT_EN     = s_ff.out_en;
  assign CAL_ACTIVE = s_ff.cal;

  // ==========================================================
  // checks
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_B);

  sequence soft_seq;
    soft_go && pins_ok;
  endsequence

  sequence cal_last;
    s_ff.st == PDC_ST_CAL && m_out && s_ff.cnt == 17'(CAL_LEN - 1);
  endsequence

  chk_pins_hold_reset: assert property (
    !pins_ok |=> s_ff.st == PDC_ST_RESET && !OUT_EN)
    else $error("pin low did not hold reset");
  chk_normal_needs_pins: assert property (
    s_ff.st != PDC_ST_RESET |-> $past(pins_ok))
    else $error("left reset with a pin low");
  chk_defaults_reload: assert property (
    !pins_ok ##1 pins_ok |-> s_ff.mdiv == `PDC_D_MDIV
      && s_ff.act_n2 == `PDC_D_N2DIV ##1 s_ff.st == PDC_ST_REFWAIT)
    else $error("defaults not reloaded on pin release");
  chk_soft_keeps_bank: assert property (
    soft_seq |=> s_ff.st == PDC_ST_RESET && s_ff.act_mdiv == $past(s_ff.mdiv)
      && s_ff.mdiv == $past(s_ff.mdiv))
    else $error("soft reset lost bank or used stale settings");
  chk_cal_needs_supply: assert property (
    s_ff.st == PDC_ST_REFWAIT ##1 s_ff.st == PDC_ST_FBWAIT
      |-> $past(SUPPLY_OK) && $past(s_ff.cnt) == 17'(REF_WAIT - 1))
    else $error("stabilization left early");
  chk_fb_wait_len: assert property (
    s_ff.st == PDC_ST_FBWAIT ##1 s_ff.st == PDC_ST_CAL
      |-> $past(n2_out) && $past(s_ff.cnt) == 17'(FB_WAIT - 1))
    else $error("feedback wait wrong length");
  chk_cal_outputs_off: assert property (
    s_ff.st == PDC_ST_CAL |-> Y == '0 && Y_ALT == '0 && !OUT_EN)
    else $error("output toggled during calibration");
  chk_cal_length: assert property (
    cal_last and pins_ok and !soft_go |=> OUT_EN && s_ff.st == PDC_ST_RUN)
    else $error("calibration end did not enable outputs");
  chk_cal_exact: assert property (
    s_ff.st == PDC_ST_CAL ##1 s_ff.st == PDC_ST_RUN |-> $past(s_ff.cnt) == 17'(CAL_LEN - 1))
    else $error("calibration wrong length");
  chk_restart_seq: assert property (
    soft_seq ##1 pins_ok |=> s_ff.st == PDC_ST_REFWAIT && s_ff.cnt == '0)
    else $error("sequencer did not restart");

endmodule : pdc_top

// *** include/pdc_consts.svh ***
// constants for the pll divider and calibration control block
`ifndef PDC_CONSTS_SVH
`define PDC_CONSTS_SVH

// ==========================================================
// register offsets
`define PDC_A_CTRL    4'h0
`define PDC_A_RDIV    4'h1
`define PDC_A_MDIV    4'h2
`define PDC_A_N1DIV   4'h3
`define PDC_A_N2DIV   4'h4
`define PDC_A_PSA     4'h5
`define PDC_A_PSB     4'h6
`define PDC_A_OUTCFG  4'h7
`define PDC_A_STATUS  4'h8

// ==========================================================
// field positions
`define PDC_B_SOFT     0
`define PDC_B_AUTO     1
`define PDC_B_SEL      2
`define PDC_B_SLEW     0
`define PDC_B_DUAL     4
`define PDC_B_ST       0
`define PDC_B_SUPPLY   3
`define PDC_B_SECSEL   4
`define PDC_B_OUTEN    5
`define PDC_B_PRIIDLE  6

// ==========================================================
// reset values (stored value is divide ratio minus one)
`define PDC_D_CTRL    3'h2
`define PDC_D_RDIV    4'h0
`define PDC_D_MDIV    14'h0000
`define PDC_D_N1DIV   8'h00
`define PDC_D_N2DIV   10'h000
`define PDC_D_PSA     3'h3
`define PDC_D_PSB     3'h3
`define PDC_D_OUTCFG  8'h00

// ==========================================================
// timing counts
`define PDC_REF_WAIT     65536
`define PDC_FB_WAIT      65536
`define PDC_CAL_LEN      131072
`define PDC_ACT_TIMEOUT  256

`endif

// *** include/pdc_pkg.sv ***
// types shared by the pll divider and calibration control block
package pdc_pkg;

  // ==========================================================
  // startup sequencer states
  typedef enum logic [2:0] {
    PDC_ST_RESET,
    PDC_ST_REFWAIT,
    PDC_ST_FBWAIT,
    PDC_ST_CAL,
    PDC_ST_RUN
  } pdc_state_t;

endpackage : pdc_pkg

// *** testbench/pdc_ref_model.sv ***
// reference and vco clock sources standing in for the board around the block
`timescale 1ns/1ps
module pdc_ref_model (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       run,
  input  wire logic [3:0] ref_half,
  output logic            pri_ref,
  output logic            sec_ref,
  output logic            vco_clk
);
  logic [3:0] ref_cnt_ff;
  logic       vco_cnt_ff;

  // ==========================================================
  // clock generation
  // all three clocks stand still low while stopped
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_cnt_ff <= 4'h0;
      vco_cnt_ff <= 1'b0;
      pri_ref    <= 1'b0;
      sec_ref    <= 1'b0;
      vco_clk    <= 1'b0;
    end else if (!run) begin
      ref_cnt_ff <= 4'h0;
      pri_ref    <= 1'b0;
      sec_ref    <= 1'b0;
      vco_clk    <= 1'b0;
    end else begin
      vco_cnt_ff <= ~vco_cnt_ff;
      if (vco_cnt_ff) vco_clk <= ~vco_clk; // slow vco keeps first stage in range
      if (ref_cnt_ff == ref_half) begin
        ref_cnt_ff <= 4'h0;
        pri_ref    <= ~pri_ref;
        sec_ref    <= ~pri_ref; // same rate and phase as primary
      end else begin
        ref_cnt_ff <= ref_cnt_ff + 4'h1;
      end
    end
  end
endmodule : pdc_ref_model

// *** testbench/pdc_top_tb.sv ***
// self-checking bench for the pll divider and calibration control block
`timescale 1ns/1ps
module pdc_top_tb
  import pdc_pkg::*;
;
  logic        MCLK;
  logic        RST_B;
  logic        POWER_DOWN_PIN_N;
  logic        HARD_RESET_PIN_N;
  logic        SUPPLY_OK;
  logic        PRI_REF;
  logic        SEC_REF;
  logic        VCO_CLK;
  logic [3:0]  ADDR;
  logic [15:0] WR_DATA;
  logic        WR_EN;
  logic        RD_EN;
  logic [15:0] RD_DATA;
  logic [7:0]  Y;
  logic [3:0]  Y_ALT;
  logic [3:0]  SLEW_FAST;
  logic        OUT_EN;
  logic        CAL_ACTIVE;
  logic        PUMP_UP;
  logic        PUMP_DN;
  logic [15:0] rd;
  int          miscompares;
  int          tests_run;
  int          toggles;
  int          ups;
  int          dns;
  int          cal_cycles;
  logic        ref_run;
  logic [3:0]  ref_half;
  logic [15:0] dflt [8] = '{16'h0002, 16'h0000, 16'h0000, 16'h0000,
                            16'h0000, 16'h0003, 16'h0003, 16'h0000};

  // ==========================================================
  // design and partner
  pdc_top #(.REF_WAIT(4), .FB_WAIT(4), .CAL_LEN(8), .ACT_TIMEOUT(16)) pdc_top_i (
    .MCLK(MCLK), .RST_B(RST_B), .POWER_DOWN_PIN_N(POWER_DOWN_PIN_N),
    .HARD_RESET_PIN_N(HARD_RESET_PIN_N), .SUPPLY_OK(SUPPLY_OK), .PRI_REF(PRI_REF),
    .SEC_REF(SEC_REF), .VCO_CLK(VCO_CLK), .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_EN(WR_EN),
    .RD_EN(RD_EN), .RD_DATA(RD_DATA), .Y(Y), .Y_ALT(Y_ALT), .SLEW_FAST(SLEW_FAST),
    .OUT_EN(OUT_EN), .CAL_ACTIVE(CAL_ACTIVE), .PUMP_UP(PUMP_UP), .PUMP_DN(PUMP_DN));

  pdc_ref_model pdc_ref_model_i (
    .clk(MCLK), .rst_b(RST_B), .run(ref_run), .ref_half(ref_half),
    .pri_ref(PRI_REF), .sec_ref(SEC_REF), .vco_clk(VCO_CLK));

  // 100 MHz clock
  always #5 MCLK = ~MCLK;

  // ==========================================================
  // access and compare tasks
  task automatic report_and_stop();
    if (miscompares == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge MCLK);
    WR_EN   <= 1'b1;
    ADDR    <= a;
    WR_DATA <= d;
    @(posedge MCLK);
    WR_EN   <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge MCLK);
    RD_EN <= 1'b1;
    ADDR  <= a;
    @(posedge MCLK);
    RD_EN <= 1'b0;
    #1;
    d = RD_DATA;
  endtask : rd_reg

  // bounded wait for the calibration flag, watching outputs while it is high
  task automatic wait_cal(input logic lvl);
    int n;
    n = 0;
    while (CAL_ACTIVE !== lvl && n < 3000) begin
      @(posedge MCLK);
      #1;
      if (CAL_ACTIVE === 1'b1)
        check("outputs_in_cal", 16'h0000, {3'h0, Y_ALT, OUT_EN, Y});
      n++;
    end
    cal_cycles = n;
    if (CAL_ACTIVE !== lvl) begin
      miscompares++;
      report_and_stop();
    end
  endtask : wait_cal

  // ==========================================================
  // main sequence
  initial begin
    MCLK = 1'b0;
    RST_B = 1'b0;
    POWER_DOWN_PIN_N = 1'b1;
    HARD_RESET_PIN_N = 1'b1;
    SUPPLY_OK = 1'b0;
    ADDR = 4'h0;
    WR_DATA = 16'h0000;
    WR_EN = 1'b0;
    RD_EN = 1'b0;
    ref_run = 1'b1;
    ref_half = 4'h3;
    miscompares = 0;
    tests_run = 0;
    repeat (10) @(posedge MCLK);
    RST_B <= 1'b1;
    // defaults after power-up
    for (int a = 0; a < 8; a++) begin
      rd_reg(a[3:0], rd);
      check("reg_default", dflt[a], rd);
    end
    // no calibration while supplies are bad
    repeat (300) @(posedge MCLK);
    rd_reg(4'h8, rd);
    check("status_no_supply", 16'h0001, rd & 16'h000F);
    rd_reg(4'hC, rd);
    check("unmapped_read", 16'h0000, rd);
    wr_reg(4'h8, 16'hFFFF);
    rd_reg(4'h8, rd);
    check("status_read_only", 16'h0001, rd & 16'h0007);
    // supplies good: wait, calibrate, run
    SUPPLY_OK <= 1'b1;
    wait_cal(1'b1);
    wait_cal(1'b0);
    check("out_en_after_cal", 16'h0001, {15'h0000, OUT_EN});
    // eight detector pulses, one per eight clocks, phase unknown at entry
    check("cal_length", 16'h0001, {15'h0000, cal_cycles >= 57 && cal_cycles <= 64});
    rd_reg(4'h8, rd);
    check("status_run", 16'h0020 | 16'h0008 | 16'(PDC_ST_RUN), rd & 16'h002F);
    // output grouping and cmos options
    wr_reg(4'h7, 16'h005A);
    @(posedge MCLK);
    #1;
    check("slew_fast", 16'h000A, {12'h000, SLEW_FAST});
    toggles = 0;
    ups = 0;
    dns = 0;
    repeat (60) begin
      @(posedge MCLK);
      #1;
      if (Y[0] !== Y[2]) toggles = toggles + 100;
      check("group_a", {12'h000, {4{Y[0]}}}, {12'h000, Y[5], Y[4], Y[1], Y[0]});
      check("group_b", {12'h000, {4{Y[2]}}}, {12'h000, Y[7], Y[6], Y[3], Y[2]});
      check("y_alt", {12'h000, Y[7:4] & 4'h5}, {12'h000, Y_ALT});
      if (Y[0] === 1'b1) toggles++;
      if (PUMP_UP === 1'b1) ups++;
      if (PUMP_DN !== 1'b0) dns++;
    end
    check("y_running", 16'h0001, {15'h0000, (toggles > 0 && toggles < 60)});
    // reference runs twice the feedback rate, so only pump up is expected
    check("pump_up_seen", 16'h0001, {15'h0000, ups > 0});
    check("pump_dn_quiet", 16'h0000, 16'(dns));
    // manual secondary select, then primary loss under auto selection
    wr_reg(4'h0, 16'h0004);
    rd_reg(4'h8, rd);
    check("manual_secondary", 16'h0010, rd & 16'h0010);
    wr_reg(4'h0, 16'h0002);
    ref_run <= 1'b0;
    repeat (40) @(posedge MCLK);
    rd_reg(4'h8, rd);
    check("auto_on_loss", 16'h0050, rd & 16'h0050);
    ref_run <= 1'b1;
    repeat (40) @(posedge MCLK);
    rd_reg(4'h8, rd);
    check("auto_back_primary", 16'h0000, rd & 16'h0050);
    // soft reset keeps the bank
    wr_reg(4'h3, 16'h0001); // ratio two keeps first stage slow
    wr_reg(4'h0, 16'h0003);
    wr_reg(4'h0, 16'h0002);
    @(posedge MCLK);
    #1;
    check("out_en_soft", 16'h0000, {15'h0000, OUT_EN});
    rd_reg(4'h3, rd);
    check("n1_kept", 16'h0001, rd);
    rd_reg(4'h0, rd);
    check("ctrl_kept", 16'h0002, rd);
    // pin resets in mid calibration restart and reload
    for (int p = 0; p < 2; p++) begin
      wait_cal(1'b1);
      wr_reg(4'h3, 16'h0001);
      @(posedge MCLK);
      if (p == 0) POWER_DOWN_PIN_N <= 1'b0;
      else HARD_RESET_PIN_N <= 1'b0;
      repeat (5) @(posedge MCLK);
      #1;
      check("held_in_reset", 16'h0000, {14'h0000, CAL_ACTIVE, OUT_EN});
      rd_reg(4'h8, rd);
      check("state_in_reset", 16'h0000, rd & 16'h0007);
      @(posedge MCLK);
      POWER_DOWN_PIN_N <= 1'b1;
      HARD_RESET_PIN_N <= 1'b1;
      repeat (3) @(posedge MCLK);
      rd_reg(4'h8, rd);
      check("state_restart", 16'h0001, rd & 16'h0007);
      rd_reg(4'h3, rd);
      check("n1_reloaded", 16'h0000, rd);
    end
    wait_cal(1'b1);
    wait_cal(1'b0);
    check("out_en_final", 16'h0001, {15'h0000, OUT_EN});
    check("cal_length_final", 16'h0001, {15'h0000, cal_cycles >= 57 && cal_cycles <= 64});
    report_and_stop();
  end
endmodule : pdc_top_tb
